/* File: core/jtb_tap_top.sv */
// Boundary-scan test port: pin sampling, instruction and data registers, serial output
`timescale 1ns/100ps
`include "jtb_cfg.svh"
module jtb_tap_top #(
   parameter logic [10:0] ID_MFG = `JTB_ID_MFG, // Arbitrary maker code
   parameter logic [15:0] ID_PART = `JTB_ID_PART, // Arbitrary part code
   parameter logic [3:0] ID_VER = `JTB_ID_VER // Arbitrary version
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdoEnableN,
   input wire logic [`JTB_BS_LEN:1] boundaryPinIn,
   input wire logic [`JTB_BS_LEN:1] boundarySysOut,
   output logic [`JTB_BS_LEN:1] boundaryPinOut,
   output logic hostBusDriveEnable,
   output logic [`JTB_DATA_W-1:0] hostBusDataOut,
   output logic interruptPinOutput,
   output logic interruptPinDriveEnable,
   output jtb_pkg::jtb_state_t tapState,
   output logic [`JTB_IR_W-1:0] currentInstruction
);
   import jtb_pkg::*;

   // Opcode decode, shared by the capture, shift and output paths
   // Data register chosen by an opcode; unlisted codes fall to bypass
   function automatic jtb_dr_t drSelect(input logic [`JTB_IR_W-1:0] op);
      jtb_dr_t sel;
      sel = SEL_BYPASS;
      case (op)
         // Code 010 is taken as sample/preload, not float
         `JTB_OP_EXTEST, `JTB_OP_SAMPLE: sel = SEL_CHAIN;
         `JTB_OP_IDCODE: sel = SEL_IDENT;
         // Bypass, clamp, factory and spare codes
         default: sel = SEL_BYPASS;
      endcase
      return sel;
   endfunction

   // Opcodes that drive the pins from the latched chain
   // Sample leaves the pins with the system logic
   function automatic logic pinsFromChain(input logic [`JTB_IR_W-1:0] op);
      return (op == `JTB_OP_EXTEST) || (op == `JTB_OP_CLAMP);
   endfunction

   // Link pins arrive from the tester's clock domain
   // Two stages each before any logic reads them
   // Stages reset low: test clock must be low at release
   // Pin synchronisers and test-clock edge detector
   logic tckSync1_reg, tckSync1_next; // First stage, read only by second
   logic tckSync2_reg, tckSync2_next; // Safe test-clock level
   logic tckPrev_reg, tckPrev_next; // Previous level for edges
   logic tmsSync1_reg, tmsSync1_next; // First stage
   logic tmsSync2_reg, tmsSync2_next; // Safe mode-select
   logic tdiSync1_reg, tdiSync1_next; // First stage
   logic tdiSync2_reg, tdiSync2_next; // Safe serial input
   logic [`JTB_BS_LEN:1] pinSync1_reg, pinSync1_next; // First stage of pin samples
   logic [`JTB_BS_LEN:1] pinSync2_reg, pinSync2_next; // Safe pin samples
   logic tckRise; // Rising edge pulse
   logic tckFall; // Falling edge pulse

   // Scan registers
   // Shift paths move on rises, latches on falls
   logic [`JTB_IR_W-1:0] irShift_reg, irShift_next; // Instruction shift path
   logic [`JTB_IR_W-1:0] irCur_reg, irCur_next; // Current instruction
   logic bypass_reg, bypass_next; // One-bit bypass stage
   logic [`JTB_ID_W-1:0] idShift_reg, idShift_next; // Identification shift path
   logic [`JTB_BS_LEN:1] bsShift_reg, bsShift_next; // Chain shift stages
   logic [`JTB_BS_LEN:1] bsLatch_reg, bsLatch_next; // Chain parallel latches
   logic tdo_reg, tdo_next; // Serial output flop
   logic tdoEnN_reg, tdoEnN_next; // Serial output enable, low drives

   // Pin output flops
   // One stage between latches or system logic and pins
   logic [`JTB_BS_LEN:1] pinOut_reg, pinOut_next; // Driven pin values

   // Decoded helpers
   // Combinational views, no state of their own
   jtb_dr_t drSel; // Register selected by current instruction
   logic [`JTB_ID_W-1:0] idWord; // Identification word
   jtb_state_t st; // Controller state

   // Link to the controller
   // Controller sees only edge pulses and mode-select
   jtb_tap_if tapBus();

   // Controller instance
   // Next-state graph kept in its own module
   jtb_tap_fsm uFsm (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus(tapBus.fsm)
   );

   // Edge pulses from the settled test clock
   // Each pulse is one cycle wide
   // Levels under one cycle may lose an edge
   // Mode-select comes from the same stage depth
   assign tckRise = tckSync2_reg & ~tckPrev_reg;
   assign tckFall = ~tckSync2_reg & tckPrev_reg;
   assign tapBus.tckRise = tckRise;
   assign tapBus.tmsBit = tmsSync2_reg;
   assign st = tapBus.state;

   // Fixed one in bit 0, then maker, part and version
   // Codes are parameters so a product can set its own
   assign idWord = {ID_VER, ID_PART, ID_MFG, `JTB_ID_FIXED};
   assign drSel = drSelect(irCur_reg);

   // Synchroniser next values
   // Plain stage-to-stage copies
   always_comb begin
      tckSync1_next = tck;
      tckSync2_next = tckSync1_reg;
      tckPrev_next = tckSync2_reg;
      tmsSync1_next = tms;
      tmsSync2_next = tmsSync1_reg;
      tdiSync1_next = tdi;
      tdiSync2_next = tdiSync1_reg;
      pinSync1_next = boundaryPinIn;
      pinSync2_next = pinSync1_reg;
   end

   // Synchroniser registers
   // Reset clears all stages to the idle low level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tckSync1_reg <= `JTB_RST_BIT;
         tckSync2_reg <= `JTB_RST_BIT;
         tckPrev_reg <= `JTB_RST_BIT;
         tmsSync1_reg <= `JTB_RST_BIT;
         tmsSync2_reg <= `JTB_RST_BIT;
         tdiSync1_reg <= `JTB_RST_BIT;
         tdiSync2_reg <= `JTB_RST_BIT;
         pinSync1_reg <= '0;
         pinSync2_reg <= '0;
      end else begin
         tckSync1_reg <= tckSync1_next;
         tckSync2_reg <= tckSync2_next;
         tckPrev_reg <= tckPrev_next;
         tmsSync1_reg <= tmsSync1_next;
         tmsSync2_reg <= tmsSync2_next;
         tdiSync1_reg <= tdiSync1_next;
         tdiSync2_reg <= tdiSync2_next;
         pinSync1_reg <= pinSync1_next;
         pinSync2_reg <= pinSync2_next;
      end
   end

   // Scan register next values
   // All scan state but the current instruction in reset holds between edges
   // Rises capture and shift, falls update and drive out
   // A slow or stopped test clock is therefore harmless
   always_comb begin
      irShift_next = irShift_reg;
      irCur_next = irCur_reg; // Held outside update and reset
      bypass_next = bypass_reg;
      idShift_next = idShift_reg;
      bsShift_next = bsShift_reg;
      bsLatch_next = bsLatch_reg; // Latches move in Update-DR only
      tdo_next = tdo_reg;
      tdoEnN_next = tdoEnN_reg;

      // Reset state restores the identification instruction
      // Forced every cycle so a shifted code cannot linger
      if (st == ST_RESET) begin
         irCur_next = `JTB_OP_IDCODE;
      end

      // Rising edge actions: capture and shift
      // In data states only the register selected by the current instruction moves
      if (tckRise) begin
         unique case (st)
            // Fixed pattern into instruction path
            // Low two bits zero, top bit one
            ST_CAP_IR: begin
               irShift_next = `JTB_IR_CAPTURE;
            end
            // Instruction bits enter at the top, leave at bit 0
            ST_SHIFT_IR: begin
               irShift_next = {tdiSync2_reg, irShift_reg[`JTB_IR_W-1:1]};
            end
            // Parallel load of the selected register
            // Bypass captures zero, identification its fixed word
            ST_CAP_DR: begin
               unique case (drSel)
                  // Pin samples only under extest or sample
                  SEL_CHAIN: bsShift_next = pinSync2_reg;
                  SEL_IDENT: idShift_next = idWord;
                  SEL_BYPASS: bypass_next = `JTB_RST_BIT;
               endcase
            end
            // One stage toward the output per edge
            // Serial input enters at the far end
            ST_SHIFT_DR: begin
               unique case (drSel)
                  SEL_CHAIN: bsShift_next = {tdiSync2_reg, bsShift_reg[`JTB_BS_LEN:2]};
                  // Least bit of the word leaves first
                  SEL_IDENT: idShift_next = {tdiSync2_reg, idShift_reg[`JTB_ID_W-1:1]};
                  // Single stage gives one clock of delay
                  SEL_BYPASS: bypass_next = tdiSync2_reg;
               endcase
            end
            // Pause, exit, select and update keep every stage
            // Explicit hold keeps every path assigned
            default: begin
               irShift_next = irShift_reg;
            end
         endcase
      end

      // Falling edge actions: updates and serial output
      // Updates land half a period after the rise into the update state
      if (tckFall) begin
         // Chain copied to latches only when it is selected
         if (st == ST_UPD_DR && drSel == SEL_CHAIN) begin
            bsLatch_next = bsShift_reg;
         end
         // New instruction becomes current
         if (st == ST_UPD_IR) begin
            irCur_next = irShift_reg;
         end
         // Output follows the path in use, floats elsewhere
         // Changing on the fall gives the tester a full half period
         // Instruction path: least bit leaves first
         if (st == ST_SHIFT_IR) begin
            tdo_next = irShift_reg[0];
            tdoEnN_next = `JTB_TDO_DRIVE_N;
         // Data path chosen by the current instruction
         end else if (st == ST_SHIFT_DR) begin
            tdoEnN_next = `JTB_TDO_DRIVE_N;
            unique case (drSel)
               SEL_CHAIN: tdo_next = bsShift_reg[1];
               SEL_IDENT: tdo_next = idShift_reg[0];
               SEL_BYPASS: tdo_next = bypass_reg;
            endcase
         end else begin
            // Released: the board pull-up sets the level
            tdoEnN_next = `JTB_TDO_IDLE_N;
         end
      end
   end

   // Scan registers
   // Only these flops hold scan state
   // Reset leaves the identification instruction current
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irShift_reg <= `JTB_IR_CAPTURE;
         irCur_reg <= `JTB_OP_IDCODE;
         bypass_reg <= `JTB_RST_BIT;
         idShift_reg <= '0;
         bsShift_reg <= '0;
         bsLatch_reg <= '0;
         tdo_reg <= `JTB_RST_BIT;
         tdoEnN_reg <= `JTB_TDO_IDLE_N;
      end else begin
         irShift_reg <= irShift_next;
         irCur_reg <= irCur_next;
         bypass_reg <= bypass_next;
         idShift_reg <= idShift_next;
         bsShift_reg <= bsShift_next;
         bsLatch_reg <= bsLatch_next;
         tdo_reg <= tdo_next;
         tdoEnN_reg <= tdoEnN_next;
      end
   end

   // Pin drive: latched chain under extest or clamp, system values otherwise
   // One flop stage keeps decode glitches off the pins
   // Clamp holds pins from latches that its bypass cannot change
   always_comb begin
      if (pinsFromChain(irCur_reg)) begin
         pinOut_next = bsLatch_reg;
      end else begin
         // Normal operation untouched, including reset state
         pinOut_next = boundarySysOut;
      end
   end

   // Pin output flops
   // Reset drives every pin low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pinOut_reg <= '0;
      end else begin
         pinOut_reg <= pinOut_next;
      end
   end

   // Data bus cells: output cell then input cell per bit
   // Input cells only observe, so they need no output
   always_comb begin
      hostBusDataOut = '0;
      for (int i = 0; i < `JTB_DATA_W; i++) begin
         hostBusDataOut[i] = pinOut_reg[`JTB_POS_DATA0_OUT - `JTB_DATA_STEP * i];
      end
   end

   // Named cells for bus enable and interrupt pin
   // Positions fixed by the chain layout constants
   assign hostBusDriveEnable = pinOut_reg[`JTB_POS_BUS_OEN];
   assign interruptPinOutput = pinOut_reg[`JTB_POS_INT_OUT];
   assign interruptPinDriveEnable = pinOut_reg[`JTB_POS_INT_OE];

   // Serial output and status
   // Status ports let a monitor follow the controller
   assign boundaryPinOut = pinOut_reg;
   assign tdo = tdo_reg;
   assign tdoEnableN = tdoEnN_reg;
   assign tapState = st;
   assign currentInstruction = irCur_reg;

endmodule

/* File: core/jtb_cfg.svh */
// Constants of the boundary-scan test port: opcodes, field layouts, cell positions, reset values
`ifndef JTB_CFG_SVH
`define JTB_CFG_SVH

// Instruction register
`define JTB_IR_W 3
`define JTB_IR_CAPTURE 3'h4
`define JTB_OP_EXTEST 3'h0
`define JTB_OP_IDCODE 3'h1
`define JTB_OP_SAMPLE 3'h2
`define JTB_OP_CLAMP 3'h3
`define JTB_OP_FACTORY 3'h5
`define JTB_OP_BYPASS 3'h7

// Identification word layout, values are arbitrary neutral codes
`define JTB_ID_W 32
`define JTB_ID_FIXED 1'h1
`define JTB_ID_MFG 11'h2a5
`define JTB_ID_PART 16'h5a3c
`define JTB_ID_VER 4'h1

// Boundary chain: cell 1 sits next to the serial output
`define JTB_BS_LEN 129
`define JTB_POS_ADDR0 11
`define JTB_POS_BUS_OEN 12
`define JTB_POS_DATA0_OUT 28
`define JTB_POS_DATA0_IN 27
`define JTB_DATA_STEP 2
`define JTB_DATA_W 8
`define JTB_POS_INT_OE 34
`define JTB_POS_INT_OUT 35

// Reset values
`define JTB_RST_BIT 1'h0
`define JTB_TDO_IDLE_N 1'h1
`define JTB_TDO_DRIVE_N 1'h0

`endif

/* File: core/jtb_pkg.sv */
// Types shared by the test port controller and its scan logic
package jtb_pkg;

   // Sixteen controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } jtb_state_t;

   // Data register placed between serial input and output
   typedef enum logic [1:0] {
      SEL_CHAIN, SEL_IDENT, SEL_BYPASS
   } jtb_dr_t;

endpackage

/* File: core/jtb_tap_if.sv */
// Carrier between the scan datapath and the test port controller
`timescale 1ns/100ps
interface jtb_tap_if;
   logic tckRise; // One-cycle pulse at each sampled test-clock rising edge
   logic tmsBit; // Mode-select level aligned with tckRise
   jtb_pkg::jtb_state_t state; // Current controller state

   // Controller side
   modport fsm (
      input tckRise,
      input tmsBit,
      output state
   );

   // Datapath side
   modport core (
      output tckRise,
      output tmsBit,
      input state
   );
endinterface

/* File: core/jtb_tap_fsm.sv */
// Sixteen-state test port controller, stepped by sampled test-clock edges
`timescale 1ns/100ps
module jtb_tap_fsm (
   input wire logic sys_clk,
   input wire logic rst,
   jtb_tap_if.fsm bus
);
   import jtb_pkg::*;

   jtb_state_t state_reg; // Present controller state
   jtb_state_t state_next; // Next controller state

   // Next state, moves only on a test-clock rising edge
   always_comb begin
      state_next = state_reg; // Hold between edges
      if (bus.tckRise) begin
         unique case (state_reg)
            // Mode-select high keeps reset; five highs reach it from anywhere
            ST_RESET: state_next = bus.tmsBit ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = bus.tmsBit ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = bus.tmsBit ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = bus.tmsBit ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = bus.tmsBit ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = bus.tmsBit ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = bus.tmsBit ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = bus.tmsBit ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_next = bus.tmsBit ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = bus.tmsBit ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_next = bus.tmsBit ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = bus.tmsBit ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = bus.tmsBit ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = bus.tmsBit ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = bus.tmsBit ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_next = bus.tmsBit ? ST_SEL_DR : ST_IDLE;
         endcase
      end
   end

   // State register, reset enters Test-Logic-Reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Present state to the datapath
   assign bus.state = state_reg;

endmodule

/* File: dv/jtb_tester.sv */
// Board tester model: drives test clock, mode select and serial input, reads serial output
`timescale 1ns/100ps
module jtb_tester (
   input wire logic sys_clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdoEnableN
);
   // Idle link: clock low, mode high, serial input at its pulled-up level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One 8-cycle test-clock period; output read late in the high phase
   task automatic pulse(input logic m, input logic d, output logic q, output logic qEnN);
      @(posedge sys_clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (3) @(posedge sys_clk);
      tck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      q = tdoEnableN ? 1'b1 : tdo; // Released line rests at its pull-up
      qEnN = tdoEnableN;
   endtask
endmodule

/* File: dv/jtb_tap_chk.sv */
// Concurrent checks on the test port top-level pins
`timescale 1ns/100ps
`include "jtb_cfg.svh"
module jtb_tap_chk
   import jtb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdoEnableN,
   input wire logic [`JTB_BS_LEN:1] boundarySysOut,
   input wire logic [`JTB_BS_LEN:1] boundaryPinOut,
   input wire logic hostBusDriveEnable,
   input wire logic [`JTB_DATA_W-1:0] hostBusDataOut,
   input wire logic interruptPinOutput,
   input wire logic interruptPinDriveEnable,
   input wire jtb_pkg::jtb_state_t tapState,
   input wire logic [`JTB_IR_W-1:0] currentInstruction
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic [2:0] tckPipe_reg, tckPipe_next; // Test clock synchroniser and edge stage
   logic [1:0] tmsPipe_reg, tmsPipe_next; // Mode select synchroniser
   logic [2:0] highRun_reg, highRun_next; // Saturating run of high mode-select rises
   logic [7:0] dataMap; // Expected data bus outputs from the chain

   // Next values of the helper state
   always_comb begin
      tckPipe_next = {tckPipe_reg[1:0], tck};
      tmsPipe_next = {tmsPipe_reg[0], tms};
      highRun_next = highRun_reg;
      if (tckPipe_reg[1] && !tckPipe_reg[2]) begin
         highRun_next = !tmsPipe_reg[1] ? 3'h0 : (highRun_reg == 3'h7) ? 3'h7 : highRun_reg + 3'h1;
      end
      for (int i = 0; i < 8; i++) begin
         dataMap[i] = boundaryPinOut[28 - 2 * i];
      end
   end

   // Helper registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tckPipe_reg <= 3'h0;
         tmsPipe_reg <= 2'h0;
         highRun_reg <= 3'h0;
      end else begin
         tckPipe_reg <= tckPipe_next;
         tmsPipe_reg <= tmsPipe_next;
         highRun_reg <= highRun_next;
      end
   end

   // Steps of the controller graph
   sequence leftPauseDr;
      $past(tapState) == ST_PAUSE_DR && tapState != ST_PAUSE_DR;
   endsequence
   sequence enterShiftIr;
      $past(tapState) == ST_CAP_IR && tapState == ST_SHIFT_IR;
   endsequence

   AST_FIVE_HIGH: assert property ($changed(highRun_reg) && highRun_reg >= 3'h5 |-> ##[0:2] tapState == ST_RESET)
      else $error("controller not in reset after five high rises");
   AST_RESET_IDCODE: assert property (tapState == ST_RESET |=> currentInstruction == `JTB_OP_IDCODE)
      else $error("reset state without identification instruction");
   AST_PAUSE_DR_EXIT: assert property (leftPauseDr |-> tapState == ST_EXIT2_DR)
      else $error("pause DR left to wrong state");
   AST_CAPIR_FIRST_BIT: assert property (enterShiftIr |-> ##[1:8] (!tdoEnableN && !tdo))
      else $error("first captured instruction bit not zero");
   AST_INSTR_HOLD: assert property ($changed(currentInstruction) |-> tapState inside {ST_UPD_IR, ST_RESET})
      else $error("instruction changed outside update or reset");
   AST_LATCH_HOLD: assert property ($past(currentInstruction) == 3'h0 && $past(currentInstruction, 2) == 3'h0
      && $changed(boundaryPinOut) |-> $past(tapState) == ST_UPD_DR)
      else $error("latched pins changed outside update DR");
   AST_SYS_PASS: assert property (!$past(rst) && !($past(currentInstruction) inside {3'h0, 3'h3})
      |-> boundaryPinOut == $past(boundarySysOut))
      else $error("pins disturbed while not under test");
   AST_BUS_MAP: assert property (hostBusDataOut == dataMap && hostBusDriveEnable == boundaryPinOut[`JTB_POS_BUS_OEN]
      && interruptPinOutput == boundaryPinOut[35] && interruptPinDriveEnable == boundaryPinOut[34])
      else $error("bus or interrupt cell mapping wrong");
   AST_ENABLE_ON: assert property ($fell(tdoEnableN) |-> tapState inside {ST_SHIFT_DR, ST_SHIFT_IR})
      else $error("output enabled outside shift");
   AST_UPDATE_EXIT: assert property ($past(tapState) inside {ST_UPD_DR, ST_UPD_IR} && !(tapState inside
      {ST_UPD_DR, ST_UPD_IR}) |-> tapState inside {ST_IDLE, ST_SEL_DR})
      else $error("update state left to wrong state");
endmodule

bind jtb_tap_top jtb_tap_chk u_chk (.sys_clk, .rst, .tck, .tms, .tdo, .tdoEnableN, .boundarySysOut, .boundaryPinOut,
   .hostBusDriveEnable, .hostBusDataOut, .interruptPinOutput, .interruptPinDriveEnable, .tapState,
   .currentInstruction);

/* File: dv/tb_jtag_tap_boundary_scan.sv */
// Testbench: reference model of the test port compared at every test-clock period
`timescale 1ns/100ps
`include "jtb_cfg.svh"
module tb_jtag_tap_boundary_scan;
   import jtb_pkg::*;
   logic sys_clk, rst, tck, tms, tdi, tdo, tdoEnableN, q, qEnN; // Pins and tester readback
   logic [`JTB_BS_LEN:1] pinIn, sysOut, pinOut; // Boundary vectors
   jtb_state_t tapState, mState; // Design and model state
   logic [2:0] curInstr, mIr, mCur; // Instruction views
   logic [128:0] mDr, mLatch; // Model data path and output latches
   int miscompares = 0, tests_run = 0, cycles = 0;
   logic [2:0] ops [5] = '{`JTB_OP_BYPASS, `JTB_OP_FACTORY, 3'h4, 3'h6, `JTB_OP_IDCODE};
   localparam logic [31:0] ID_WORD = {`JTB_ID_VER, `JTB_ID_PART, `JTB_ID_MFG, `JTB_ID_FIXED};

   jtb_tap_top dut (.sys_clk, .rst, .tck, .tms, .tdi, .tdo, .tdoEnableN, .boundaryPinIn(pinIn),
      .boundarySysOut(sysOut), .boundaryPinOut(pinOut), .hostBusDriveEnable(), .hostBusDataOut(),
      .interruptPinOutput(), .interruptPinDriveEnable(), .tapState, .currentInstruction(curInstr));
   jtb_tester u_tester (.sys_clk, .tck, .tms, .tdi, .tdo, .tdoEnableN);

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Cycle ceiling against hangs
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // Value comparison
   task automatic cmp(input logic [128:0] got, input logic [128:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Controller graph
   function automatic jtb_state_t nxt(jtb_state_t s, logic m);
      case (s)
         ST_RESET: return m ? ST_RESET : ST_IDLE;
         ST_IDLE, ST_UPD_DR, ST_UPD_IR: return m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR, ST_SHIFT_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: return m ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: return m ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: return m ? ST_UPD_DR : ST_SHIFT_DR;
         ST_SEL_IR: return m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR, ST_SHIFT_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: return m ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: return m ? ST_EXIT2_IR : ST_PAUSE_IR;
         default: return m ? ST_UPD_IR : ST_SHIFT_IR;
      endcase
   endfunction

   function automatic logic [128:0] rv();
      return {$urandom, $urandom, $urandom, $urandom, 1'($urandom)};
   endfunction

   // One test-clock period through model and design
   task automatic step(input logic m, input logic d);
      int len;
      logic eTdo, eEnN;
      len = (mCur == 3'h0 || mCur == 3'h2) ? 129 : (mCur == 3'h1) ? 32 : 1;
      eEnN = !(mState inside {ST_SHIFT_DR, ST_SHIFT_IR});
      eTdo = (mState == ST_SHIFT_IR) ? mIr[0] : mDr[0];
      if (mState == ST_UPD_IR) mCur = mIr;
      if (mState == ST_UPD_DR && len == 129) mLatch = mDr;
      case (mState)
         ST_CAP_IR: mIr = `JTB_IR_CAPTURE;
         ST_SHIFT_IR: mIr = {d, mIr[2:1]};
         ST_CAP_DR: mDr = (len == 129) ? pinIn : (len == 32) ? 129'(ID_WORD) : '0;
         ST_SHIFT_DR: mDr = (mDr >> 1) | (129'(d) << (len - 1));
         default: ;
      endcase
      mState = nxt(mState, m);
      if (mState == ST_RESET) mCur = `JTB_OP_IDCODE;
      u_tester.pulse(m, d, q, qEnN);
      cmp(tapState, mState);
      cmp(curInstr, mCur);
      cmp(qEnN, eEnN);
      if (!eEnN) cmp(q, eTdo);
      if (mState != ST_RESET) cmp(pinOut, (mCur == 3'h0 || mCur == 3'h3) ? mLatch : sysOut);
   endtask

   // Scan of n bits from idle, optionally pausing in its pause state before and after the shift
   task automatic scan(input logic ir, input int n, input logic [128:0] v, input logic pz);
      step(1'b1, 1'($urandom));
      if (ir) step(1'b1, 1'($urandom));
      step(1'b0, 1'($urandom));
      if (pz) begin
         step(1'b1, 1'($urandom));
         step(1'b0, 1'($urandom));
         step(1'b0, 1'($urandom));
         step(1'b1, 1'($urandom));
      end
      step(1'b0, 1'($urandom));
      for (int i = 0; i < n; i++) step(i == n - 1, v[i]);
      if (pz) begin
         step(1'b0, 1'($urandom));
         step(1'b1, 1'($urandom));
      end
      step(1'b1, 1'($urandom));
      step(1'b0, 1'($urandom));
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'hdf7f));
      rst = 1'b1;
      pinIn = '0;
      sysOut = '0;
      mState = ST_RESET;
      mCur = `JTB_OP_IDCODE;
      mIr = 3'h0;
      mDr = '0;
      mLatch = '0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      cmp(curInstr, `JTB_OP_IDCODE);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
      $display("test reset and idle done");
      scan(1'b0, 32, rv(), 1'b0);
      $display("test identification done");
      @(posedge sys_clk);
      pinIn <= rv();
      sysOut <= rv();
      scan(1'b1, 3, `JTB_OP_SAMPLE, 1'b1);
      scan(1'b0, 129, rv(), 1'b0);
      scan(1'b1, 3, `JTB_OP_EXTEST, 1'b0);
      scan(1'b0, 129, rv(), 1'b1);
      scan(1'b1, 3, `JTB_OP_CLAMP, 1'b0);
      scan(1'b0, 8, rv(), 1'b1);
      $display("test boundary chain done");
      foreach (ops[i]) begin
         scan(1'b1, 3, ops[i], i[0]);
         scan(1'b0, 8, rv(), !i[0]);
      end
      $display("test opcode sweep done");
      repeat (300) step(1'($urandom), 1'($urandom));
      repeat (5) step(1'b1, 1'($urandom));
      $display("test random walk done");
      tally_and_finish();
   end
endmodule
